// file: core/dlt_pkg.sv
// Shared constants for the dual legacy counter/timer block.
// Assumes a single system clock; all timing is expressed in its cycles.
package dlt_pkg;
  localparam int MODE_W = 2;
  localparam logic [1:0] MODE_13 = 2'h0;
  localparam logic [1:0] MODE_16 = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;
  localparam int SCALE_W = 2;
  localparam logic [1:0] SCALE_0 = 2'h0;
  localparam logic [1:0] SCALE_1 = 2'h1;
  localparam logic [1:0] SCALE_2 = 2'h2;
  localparam int BYTE_W = 8;
  localparam int LOW13_W = 5;
  localparam int CNT13_W = 13;
  localparam int CNT16_W = 16;
  localparam int PRE_CNT_W = 8;
  localparam logic [7:0] BYTE_RESET = 8'h00;
endpackage

// file: core/dlt_sync_edge.sv
// Pin synchroniser with falling-edge detector.
// Assumes the pin is asynchronous to clk and holds each level two cycles or more.
`timescale 1ns/1ps
module dlt_sync_edge (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic level,
  output logic fall
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;
  logic lvl_next;
  logic fall_reg;
  logic fall_next;

  // A change counts only once two later stages agree, filtering a late-settling first stage
  always_comb begin
    lvl_next = lvl_reg;
    if (s2_reg == s3_reg) begin
      lvl_next = s3_reg;
    end
    fall_next = lvl_reg & ~lvl_next;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      lvl_reg <= 1'b1;
      fall_reg <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
      fall_reg <= fall_next;
    end
  end

  assign level = lvl_reg;
  assign fall = fall_reg;
endmodule

// file: core/dlt_timers.sv
// Two 16-bit counter/timers with 13-bit, 16-bit and 8-bit reload modes; split mode on timer A only, timer B halts in it.
// Assumes control bits come from software registers on clk; pins are asynchronous.
`timescale 1ns/1ps
module dlt_timers #(
  parameter int PRE_DIV0 = 12,
  parameter int PRE_DIV1 = 4,
  parameter int PRE_DIV2 = 48,
  parameter int PRE_DIV3 = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [dlt_pkg::MODE_W-1:0] timer_a_mode,
  input wire logic [dlt_pkg::MODE_W-1:0] timer_b_mode,
  input wire logic timer_a_counter_select,
  input wire logic timer_b_counter_select,
  input wire logic timer_a_gate_bit,
  input wire logic timer_b_gate_bit,
  input wire logic timer_a_run_bit,
  input wire logic timer_b_run_bit,
  input wire logic timer_a_sysclk_select,
  input wire logic timer_b_sysclk_select,
  input wire logic [dlt_pkg::SCALE_W-1:0] clock_scale_field,
  input wire logic gate_a_polarity,
  input wire logic gate_b_polarity,
  input wire logic timer_a_irq_enable,
  input wire logic timer_b_irq_enable,
  input wire logic count_pin_a,
  input wire logic count_pin_b,
  input wire logic gate_input_a,
  input wire logic gate_input_b,
  input wire logic [dlt_pkg::BYTE_W-1:0] wr_data,
  input wire logic wr_a_low,
  input wire logic wr_a_high,
  input wire logic wr_b_low,
  input wire logic wr_b_high,
  input wire logic clr_a_flag,
  input wire logic clr_b_flag,
  output logic [dlt_pkg::BYTE_W-1:0] timer_a_low_byte,
  output logic [dlt_pkg::BYTE_W-1:0] timer_a_high_byte,
  output logic [dlt_pkg::BYTE_W-1:0] timer_b_low_byte,
  output logic [dlt_pkg::BYTE_W-1:0] timer_b_high_byte,
  output logic timer_a_overflow_flag,
  output logic timer_b_overflow_flag,
  output logic timer_a_irq,
  output logic timer_b_irq,
  output logic timer_b_overflow_pulse
);
  import dlt_pkg::*;

  // One count step; returns {overflow, high, low}
  function automatic logic [CNT16_W:0] cnt_step(input logic [MODE_W-1:0] mode, input logic [BYTE_W-1:0] lo,
                                                input logic [BYTE_W-1:0] hi, input logic inc);
    logic [CNT13_W:0] c13;
    logic [CNT16_W:0] c16;
    logic [BYTE_W:0] c8;
    logic [CNT16_W:0] r;
    c13 = {1'b0, hi, lo[LOW13_W-1:0]} + {{CNT13_W{1'b0}}, 1'b1};
    c16 = {1'b0, hi, lo} + {{CNT16_W{1'b0}}, 1'b1};
    c8 = {1'b0, lo} + {{BYTE_W{1'b0}}, 1'b1};
    r = {1'b0, hi, lo};
    if (inc) begin
      case (mode)
        // Upper low-byte bits are left as they are; software masks them
        MODE_13: r = {c13[CNT13_W], c13[CNT13_W-1:LOW13_W], lo[BYTE_W-1:LOW13_W], c13[LOW13_W-1:0]};
        MODE_16: r = c16;
        MODE_RELOAD: r = {c8[BYTE_W], hi, c8[BYTE_W] ? hi : c8[BYTE_W-1:0]};
        default: r = {c8[BYTE_W], hi, c8[BYTE_W-1:0]};
      endcase
    end
    return r;
  endfunction

  logic lvl_cnt_a;
  logic lvl_cnt_b;
  logic fall_a;
  logic fall_b;
  logic gate_lvl_a;
  logic gate_lvl_b;

  dlt_sync_edge u_cnt_a (.clk(clk), .rst_b(rst_b), .pin(count_pin_a), .level(lvl_cnt_a), .fall(fall_a));
  dlt_sync_edge u_cnt_b (.clk(clk), .rst_b(rst_b), .pin(count_pin_b), .level(lvl_cnt_b), .fall(fall_b));
  dlt_sync_edge u_gate_a (.clk(clk), .rst_b(rst_b), .pin(gate_input_a), .level(gate_lvl_a), .fall());
  dlt_sync_edge u_gate_b (.clk(clk), .rst_b(rst_b), .pin(gate_input_b), .level(gate_lvl_b), .fall());

  // Prescaler: a one-cycle enable instead of a derived clock avoids a second domain
  logic [PRE_CNT_W-1:0] pre_cnt_reg;
  logic [PRE_CNT_W-1:0] pre_cnt_next;
  logic [PRE_CNT_W-1:0] pre_last;
  logic pre_tick;

  always_comb begin
    case (clock_scale_field)
      SCALE_0: pre_last = PRE_CNT_W'(PRE_DIV0 - 1);
      SCALE_1: pre_last = PRE_CNT_W'(PRE_DIV1 - 1);
      SCALE_2: pre_last = PRE_CNT_W'(PRE_DIV2 - 1);
      default: pre_last = PRE_CNT_W'(PRE_DIV3 - 1);
    endcase
    // A scale change mid-period finishes early rather than running to wrap
    pre_tick = (pre_cnt_reg >= pre_last);
    pre_cnt_next = pre_tick ? '0 : pre_cnt_reg + {{(PRE_CNT_W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt_reg <= '0;
    end else begin
      pre_cnt_reg <= pre_cnt_next;
    end
  end

  logic [BYTE_W-1:0] a_lo_reg;
  logic [BYTE_W-1:0] a_hi_reg;
  logic [BYTE_W-1:0] b_lo_reg;
  logic [BYTE_W-1:0] b_hi_reg;
  logic a_flag_reg;
  logic b_flag_reg;
  logic b_pulse_reg;
  logic [BYTE_W-1:0] a_lo_next;
  logic [BYTE_W-1:0] a_hi_next;
  logic [BYTE_W-1:0] b_lo_next;
  logic [BYTE_W-1:0] b_hi_next;
  logic a_flag_next;
  logic b_flag_next;
  logic b_pulse_next;
  logic tick_int_a;
  logic tick_int_b;
  logic split;
  logic gate_ok_a;
  logic gate_ok_b;
  logic inc_a;
  logic inc_a_hi;
  logic inc_b;
  logic [CNT16_W:0] step_a;
  logic [CNT16_W:0] step_b;
  logic [BYTE_W:0] a_hi_sum;
  logic a_hi_ovf;

  always_comb begin
    tick_int_a = timer_a_sysclk_select | pre_tick;
    tick_int_b = timer_b_sysclk_select | pre_tick;
    split = (timer_a_mode == MODE_SPLIT);
    gate_ok_a = ~timer_a_gate_bit | (gate_lvl_a == gate_a_polarity);
    gate_ok_b = ~timer_b_gate_bit | (gate_lvl_b == gate_b_polarity);
    inc_a = timer_a_run_bit & gate_ok_a & (timer_a_counter_select ? fall_a : tick_int_a);
    inc_a_hi = split & timer_b_run_bit & tick_int_a;
    if (timer_b_mode == MODE_SPLIT) begin
      inc_b = 1'b0;
    end else if (split) begin
      inc_b = tick_int_b;
    end else begin
      inc_b = timer_b_run_bit & gate_ok_b & (timer_b_counter_select ? fall_b : tick_int_b);
    end
    step_a = cnt_step(timer_a_mode, a_lo_reg, a_hi_reg, inc_a);
    step_b = cnt_step(timer_b_mode, b_lo_reg, b_hi_reg, inc_b);
    a_hi_sum = {1'b0, a_hi_reg} + {{BYTE_W{1'b0}}, 1'b1};
    a_hi_ovf = inc_a_hi & a_hi_sum[BYTE_W];

    // Software byte writes take priority over a count in the same cycle
    a_lo_next = wr_a_low ? wr_data : step_a[BYTE_W-1:0];
    if (wr_a_high) begin
      a_hi_next = wr_data;
    end else if (split) begin
      a_hi_next = inc_a_hi ? a_hi_sum[BYTE_W-1:0] : a_hi_reg;
    end else begin
      a_hi_next = step_a[CNT16_W-1:BYTE_W];
    end
    b_lo_next = wr_b_low ? wr_data : step_b[BYTE_W-1:0];
    b_hi_next = wr_b_high ? wr_data : step_b[CNT16_W-1:BYTE_W];

    // Hardware set wins over a clear in the same cycle
    a_flag_next = step_a[CNT16_W] | (a_flag_reg & ~clr_a_flag);
    b_flag_next = (split ? a_hi_ovf : step_b[CNT16_W]) | (b_flag_reg & ~clr_b_flag);
    b_pulse_next = step_b[CNT16_W];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      a_lo_reg <= BYTE_RESET;
      a_hi_reg <= BYTE_RESET;
      b_lo_reg <= BYTE_RESET;
      b_hi_reg <= BYTE_RESET;
      a_flag_reg <= 1'b0;
      b_flag_reg <= 1'b0;
      b_pulse_reg <= 1'b0;
    end else begin
      a_lo_reg <= a_lo_next;
      a_hi_reg <= a_hi_next;
      b_lo_reg <= b_lo_next;
      b_hi_reg <= b_hi_next;
      a_flag_reg <= a_flag_next;
      b_flag_reg <= b_flag_next;
      b_pulse_reg <= b_pulse_next;
    end
  end

  assign timer_a_low_byte = a_lo_reg;
  assign timer_a_high_byte = a_hi_reg;
  assign timer_b_low_byte = b_lo_reg;
  assign timer_b_high_byte = b_hi_reg;
  assign timer_a_overflow_flag = a_flag_reg;
  assign timer_b_overflow_flag = b_flag_reg;
  assign timer_a_irq = a_flag_reg & timer_a_irq_enable;
  assign timer_b_irq = b_flag_reg & timer_b_irq_enable;
  assign timer_b_overflow_pulse = b_pulse_reg;
endmodule

// file: tb/dlt_pin_model.sv
// Count-pin source: a burst of five falling edges.
// Assumes go is a one-cycle request while busy is low.
`timescale 1ns/1ps
module dlt_pin_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic go,
  output logic pin,
  output logic busy
);
  logic [9:0] ph_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) ph_reg <= 10'h000;
    else if (go && !busy) ph_reg <= 10'h014;
    else if (busy) ph_reg <= ph_reg - 10'h001;
  end
  assign busy = ph_reg != 10'h000;
  // Two cycles per level, so events arrive at a quarter of clk
  assign pin = ~ph_reg[1];
endmodule

// file: tb/dlt_timers_properties.sv
// Port checker for the counter/timer block.
// Assumes it is bound onto dlt_timers; one clock domain.
`timescale 1ns/1ps
module dlt_timers_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] timer_a_mode,
  input wire logic timer_a_counter_select,
  input wire logic timer_a_gate_bit,
  input wire logic timer_a_run_bit,
  input wire logic timer_b_run_bit,
  input wire logic timer_a_sysclk_select,
  input wire logic timer_a_irq_enable,
  input wire logic timer_b_irq_enable,
  input wire logic [7:0] wr_data,
  input wire logic wr_a_low,
  input wire logic wr_a_high,
  input wire logic clr_a_flag,
  input wire logic [7:0] timer_a_low_byte,
  input wire logic [7:0] timer_a_high_byte,
  input wire logic timer_a_overflow_flag,
  input wire logic timer_b_overflow_flag,
  input wire logic timer_a_irq,
  input wire logic timer_b_irq
);
  import dlt_pkg::*;
  wire a_sys = timer_a_run_bit & ~timer_a_gate_bit & timer_a_sysclk_select & ~timer_a_counter_select
    & ~wr_a_low & ~wr_a_high;
  wire [15:0] a_cnt = {timer_a_high_byte, timer_a_low_byte};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_wr_low_load: assert property (wr_a_low |=> timer_a_low_byte == $past(wr_data))
    else $error("low byte write lost");
  a_irq_a_follow: assert property (timer_a_irq == (timer_a_overflow_flag & timer_a_irq_enable))
    else $error("timer a irq wrong");
  a_irq_b_follow: assert property (timer_b_irq == (timer_b_overflow_flag & timer_b_irq_enable))
    else $error("timer b irq wrong");
  a_flag_sticky: assert property (timer_a_overflow_flag & !clr_a_flag |=> timer_a_overflow_flag)
    else $error("flag dropped");
  a_run_stop: assert property (!timer_a_run_bit & !timer_b_run_bit & !wr_a_low & !wr_a_high
    |=> $stable(a_cnt))
    else $error("stopped timer moved");
  a_inc_sixteen: assert property (a_sys && timer_a_mode == MODE_16 |=> a_cnt == $past(a_cnt) + 16'h1)
    else $error("16-bit count step wrong");
  a_wrap_flag: assert property (a_sys && timer_a_mode == MODE_16 && a_cnt == 16'hFFFF
    |=> timer_a_overflow_flag)
    else $error("no flag on wrap");
  a_reload_low: assert property (a_sys && timer_a_mode == MODE_RELOAD && timer_a_low_byte == 8'hFF
    |=> timer_a_low_byte == $past(timer_a_high_byte) && $stable(timer_a_high_byte))
    else $error("reload wrong");
  a_wr_high_load: assert property (wr_a_high |=> timer_a_high_byte == $past(wr_data))
    else $error("high byte write lost");
  c_irq: cover property (timer_a_irq);
  c_reload: cover property (a_sys && timer_a_mode == MODE_RELOAD && timer_a_low_byte == 8'hFF);
  c_flag_b: cover property (timer_b_overflow_flag);
endmodule
bind dlt_timers dlt_timers_chk chk (.*);

// file: tb/dual_legacy_counter_timers_test.sv
// Self-checking bench for the counter/timer block.
// Assumes the design, checker and pin model compile first.
`timescale 1ns/1ps
module dual_legacy_counter_timers_test;
  import dlt_pkg::*;
  localparam int PD[4] = '{2, 3, 4, 2};
  logic clk = 0, rst_b = 0, go = 0, busy_a, busy_b, count_pin_a, count_pin_b;
  logic [1:0] timer_a_mode = 0, timer_b_mode = 0, clock_scale_field = 0;
  logic timer_a_counter_select = 0, timer_b_counter_select = 0, timer_a_gate_bit = 0, timer_b_gate_bit = 0;
  logic timer_a_run_bit = 0, timer_b_run_bit = 0, timer_a_sysclk_select = 1, timer_b_sysclk_select = 1;
  logic gate_a_polarity = 0, gate_b_polarity = 1, timer_a_irq_enable = 0, timer_b_irq_enable = 0;
  logic gate_input_a = 1, gate_input_b = 0, clr_a_flag = 0, clr_b_flag = 0;
  logic wr_a_low = 0, wr_a_high = 0, wr_b_low = 0, wr_b_high = 0;
  logic [7:0] wr_data = 0, timer_a_low_byte, timer_a_high_byte, timer_b_low_byte, timer_b_high_byte;
  logic timer_a_overflow_flag, timer_b_overflow_flag, timer_a_irq, timer_b_irq, timer_b_overflow_pulse;
  int failures = 0, n_checks = 0, cycles = 0;
  dlt_timers #(.PRE_DIV0(PD[0]), .PRE_DIV1(PD[1]), .PRE_DIV2(PD[2]), .PRE_DIV3(PD[3])) uut (.*);
  dlt_pin_model pa (.clk, .rst_b, .go, .pin(count_pin_a), .busy(busy_a));
  dlt_pin_model pb (.clk, .rst_b, .go, .pin(count_pin_b), .busy(busy_b));
  always #25 clk = ~clk;
  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      end_sim;
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Strobe order {b high, b low, a high, a low}; idle cycle after keeps strobes single-assigned
  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    {wr_b_high, wr_b_low, wr_a_high, wr_a_low} = s;
    wr_data = d;
    cyc(1);
    {wr_b_high, wr_b_low, wr_a_high, wr_a_low} = 4'h0;
    cyc(1);
  endtask
  task automatic run_a(input int n);
    timer_a_run_bit = 1;
    cyc(n);
    timer_a_run_bit = 0;
    // Idle edge so a following run never rewrites the run bit in the same step
    cyc(1);
  endtask
  task automatic clr;
    clr_a_flag = 1;
    cyc(1);
    clr_a_flag = 0;
  endtask
  initial begin
    cyc(10);
    rst_b = 1;
    cyc(1);
    chk("reset", {timer_a_high_byte, timer_b_low_byte}, 16'h0000);
    timer_a_mode = MODE_16;
    timer_a_irq_enable = 1;
    wr(4'h2, 8'hFF);
    wr(4'h1, 8'hFD);
    run_a(3);
    chk("a16", {timer_a_high_byte, timer_a_low_byte}, 16'h0000);
    chk("flag irq", 16'({timer_a_overflow_flag, timer_a_irq}), 16'h0003);
    run_a(2);
    chk("resume", {timer_a_high_byte, timer_a_low_byte}, 16'h0002);
    clr;
    timer_a_mode = MODE_13;
    wr(4'h2, 8'hFF);
    wr(4'h1, 8'hFE);
    run_a(2);
    chk("a13", 16'({timer_a_high_byte, timer_a_low_byte[4:0], timer_a_overflow_flag}), 16'h0001);
    clr;
    timer_a_mode = MODE_RELOAD;
    wr(4'h2, 8'hF0);
    wr(4'h1, 8'hFE);
    run_a(3);
    chk("reload", {timer_a_high_byte, timer_a_low_byte}, 16'hF0F1);
    chk("reload flag", 16'(timer_a_overflow_flag), 16'h0001);
    clr;
    timer_a_mode = MODE_16;
    timer_a_gate_bit = 1;
    wr(4'h3, 8'h00);
    timer_a_run_bit = 1;
    cyc(10);
    gate_input_a = 0;
    cyc(10);
    gate_input_a = 1;
    cyc(10);
    timer_a_run_bit = 0;
    timer_a_gate_bit = 0;
    chk("gate", 16'(timer_a_low_byte), 16'h000A);
    timer_a_sysclk_select = 0;
    for (int s = 0; s < 4; s++) begin
      clock_scale_field = s[1:0];
      cyc(300);
      wr(4'h3, 8'h00);
      run_a(12);
      chk("prescale", 16'(timer_a_low_byte), 16'(12 / PD[s]));
    end
    timer_a_sysclk_select = 1;
    timer_a_counter_select = 1;
    timer_b_counter_select = 1;
    timer_b_gate_bit = 1;
    gate_input_b = 1;
    wr(4'hF, 8'h00);
    timer_a_run_bit = 1;
    timer_b_run_bit = 1;
    go = 1;
    cyc(1);
    go = 0;
    for (int i = 0; i < 40 && busy_a; i++) cyc(1);
    cyc(8);
    chk("pin a", 16'(timer_a_low_byte), 16'h0005);
    chk("pin b", 16'(timer_b_low_byte), 16'h0005);
    timer_a_run_bit = 0;
    timer_a_counter_select = 0;
    timer_a_mode = MODE_SPLIT;
    timer_b_mode = MODE_SPLIT;
    wr(4'h3, 8'h00);
    cyc(4);
    // High half counts the edge after its write and four more
    chk("split a", {timer_a_high_byte, timer_a_low_byte}, 16'h0500);
    chk("halt b", 16'(timer_b_low_byte), 16'h0005);
    // High half of A wraps into flag B while B stays halted in mode 3
    timer_b_irq_enable = 1;
    wr(4'hE, 8'hFF);
    chk("split flag b", 16'({timer_b_overflow_flag, timer_b_irq, timer_b_overflow_pulse}), 16'h0006);
    chk("halt b bytes", {timer_b_high_byte, timer_b_low_byte}, 16'hFFFF);
    // B now runs on internal ticks regardless of run, gate and pin; its wrap must not set flag B
    timer_b_mode = MODE_16;
    clr_b_flag = 1;
    cyc(1);
    clr_b_flag = 0;
    chk("split b wrap", 16'({timer_b_overflow_flag, timer_b_overflow_pulse}), 16'h0001);
    chk("split b count", {timer_b_high_byte, timer_b_low_byte}, 16'h0000);
    cyc(1);
    chk("b pulse ends", 16'(timer_b_overflow_pulse), 16'h0000);
    end_sim;
  end
endmodule
